// *** asc_pkg.sv ***
// Package for the converter sequence control block
package asc_pkg;

  // ********************************************
  // Register offsets
  // ********************************************
  localparam logic [3:0] ADDR_CTRL_TWO = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;
  localparam logic [3:0] ADDR_SEQ_STATE = 4'h3;

  // ********************************************
  // Field positions and masks
  // ********************************************
  localparam int REF_CFG_MSB = 15;
  localparam int REF_CFG_LSB = 13;
  localparam int OFFSET_CAL_POS = 12;
  localparam int SCAN_POS = 10;
  localparam int RSVD_READ_POS = 7;
  localparam int SEQ_IRQ_MSB = 5;
  localparam int SEQ_IRQ_LSB = 2;
  localparam int RSVD_ZERO_POS = 1;
  localparam int ALT_MUX_POS = 0;
  // Writable bits: 15-12, 10, 5-2, 1, 0
  localparam logic [15:0] CTRL_WRITE_MASK = 16'hf43f;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [2:0] REF_SUPPLY_GROUND = 3'h0;
  localparam logic [3:0] SEQ_IRQ_RESERVED = 4'hf;

  // ********************************************
  // Interrupt status bits
  // ********************************************
  localparam int IRQ_SEQ_POS = 0;
  localparam int IRQ_CAL_POS = 1;
  localparam int IRQ_RSVD_POS = 2;
  localparam int IRQ_WIDTH = 3;

  // ********************************************
  // Types
  // ********************************************
  typedef enum logic [1:0] {
    ASC_IDLE = 2'b00,
    ASC_SAMPLE = 2'b01,
    ASC_CONVERT = 2'b11
  } asc_phase_e;

  typedef struct packed {
    logic [2:0] ref_config_field;
    logic offset_cal_bit;
    logic scan_first_mux_bit;
    logic [3:0] sequences_per_irq_field;
    logic reserved_zero;
    logic alternate_mux_bit;
  } asc_ctrl_s;

  typedef struct packed {
    logic cal_mode;
    logic inputs_to_ground;
    logic switches_open;
    logic use_mux_b;
    logic scan_enable;
    logic [2:0] ref_select;
  } asc_analog_s;

endpackage

// *** asc_seq_counter.sv ***
// Sequence counter raising the per-interrupt event
`timescale 1ns/10ps
`default_nettype none
module asc_seq_counter #(
  parameter int CNT_WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic seq_done,
  input wire logic [CNT_WIDTH-1:0] seq_per_irq,
  input wire logic restart,
  output logic irq_event,
  output logic [CNT_WIDTH-1:0] seq_count
);

  typedef struct packed {
    logic [CNT_WIDTH-1:0] count;
    logic event_out;
  } asc_cnt_s;

  asc_cnt_s st;
  asc_cnt_s next_st;

  always_comb begin
    next_st = st;
    next_st.event_out = 1'b0;
    if (restart) begin
      next_st.count = '0;
    end else if (seq_done) begin
      // Code n raises an event after n+1 sequences
      if (st.count >= seq_per_irq) begin
        next_st.count = '0;
        next_st.event_out = 1'b1;
      end else begin
        next_st.count = st.count + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign irq_event = st.event_out;
  assign seq_count = st.count;

endmodule
`default_nettype wire

// *** asc_top.sv ***
// Converter sequence control: register, mux alternation, scan, calibration
// Operation
// - Top three bits pick references; 000 means analog supply and ground.
// - Offset calibration bit one converts offset; zero converts selected input.
// - During calibration inputs and switches disconnect, inputs tie to ground.
// - Calibration ignores pin configuration and selected channel.
// - Scan bit one scans first mux inputs outside calibration; zero does not scan.
// - Four-bit field sets sequences per interrupt; code 1111 reserved.
// - Alternate bit: first sample mux A, then B, A, B.
// - Unimplemented bits eleven, nine, eight, six read zero.
`timescale 1ns/10ps
`default_nettype none
module asc_top #(
  parameter int PIN_CFG_WIDTH = 12,
  parameter int CHAN_WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  input wire logic sample_start,
  input wire logic seq_done,
  input wire logic [PIN_CFG_WIDTH-1:0] analog_pin_config_reg,
  input wire logic [CHAN_WIDTH-1:0] chan_sel_a,
  input wire logic [CHAN_WIDTH-1:0] chan_sel_b,
  output logic [PIN_CFG_WIDTH-1:0] pin_switch_en,
  output logic [CHAN_WIDTH-1:0] conv_channel,
  output logic inputs_to_ground,
  output logic [2:0] ref_select,
  output logic use_mux_b,
  output logic scan_enable,
  output logic cal_mode,
  output logic irq
);

  // ********************************************
  // State
  // ********************************************
  typedef struct packed {
    asc_pkg::asc_ctrl_s ctrl;
    logic [asc_pkg::IRQ_WIDTH-1:0] status;
    logic [asc_pkg::IRQ_WIDTH-1:0] mask;
    logic [15:0] rdata;
    logic next_is_b;
    asc_pkg::asc_phase_e phase;
    asc_pkg::asc_analog_s ana;
    logic [PIN_CFG_WIDTH-1:0] sw_en;
    logic [CHAN_WIDTH-1:0] chan;
    logic irq;
  } asc_state_s;

  asc_state_s st;
  asc_state_s next_st;
  logic seq_event;
  logic [3:0] seq_count;
  logic cal_restart;

  function automatic logic [15:0] ctrl_to_word(input asc_pkg::asc_ctrl_s c);
    logic [15:0] w;
    w = 16'h0000;
    w[asc_pkg::REF_CFG_MSB:asc_pkg::REF_CFG_LSB] = c.ref_config_field;
    w[asc_pkg::OFFSET_CAL_POS] = c.offset_cal_bit;
    w[asc_pkg::SCAN_POS] = c.scan_first_mux_bit;
    w[asc_pkg::SEQ_IRQ_MSB:asc_pkg::SEQ_IRQ_LSB] = c.sequences_per_irq_field;
    w[asc_pkg::RSVD_ZERO_POS] = c.reserved_zero;
    w[asc_pkg::ALT_MUX_POS] = c.alternate_mux_bit;
    return w;
  endfunction

  // Restart counting whenever software rewrites the control register
  assign cal_restart = wr_en && (addr == asc_pkg::ADDR_CTRL_TWO);

  asc_seq_counter #(
    .CNT_WIDTH(4)
  ) u_seq_counter (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .seq_done(seq_done),
    .seq_per_irq(st.ctrl.sequences_per_irq_field),
    .restart(cal_restart),
    .irq_event(seq_event),
    .seq_count(seq_count)
  );

  // ********************************************
  // Next state
  // ********************************************
  always_comb begin
    logic [15:0] w;
    logic [asc_pkg::IRQ_WIDTH-1:0] set_bits;
    w = 16'h0000;
    set_bits = '0;
    next_st = st;
    next_st.rdata = 16'h0000;

    // Register writes
    if (wr_en) begin
      case (addr)
        asc_pkg::ADDR_CTRL_TWO: begin
          w = wdata & asc_pkg::CTRL_WRITE_MASK;
          next_st.ctrl.ref_config_field = w[asc_pkg::REF_CFG_MSB:asc_pkg::REF_CFG_LSB];
          next_st.ctrl.offset_cal_bit = w[asc_pkg::OFFSET_CAL_POS];
          next_st.ctrl.scan_first_mux_bit = w[asc_pkg::SCAN_POS];
          next_st.ctrl.sequences_per_irq_field = w[asc_pkg::SEQ_IRQ_MSB:asc_pkg::SEQ_IRQ_LSB];
          next_st.ctrl.reserved_zero = w[asc_pkg::RSVD_ZERO_POS];
          next_st.ctrl.alternate_mux_bit = w[asc_pkg::ALT_MUX_POS];
          next_st.next_is_b = 1'b0;
        end
        asc_pkg::ADDR_IRQ_STATUS: next_st.status = st.status & ~wdata[asc_pkg::IRQ_WIDTH-1:0];
        asc_pkg::ADDR_IRQ_MASK: next_st.mask = wdata[asc_pkg::IRQ_WIDTH-1:0];
        default: next_st.mask = st.mask;
      endcase
    end

    // Register reads, data one cycle later
    if (rd_en) begin
      case (addr)
        // Bits 11, 9, 8, 6 and 7 built as zero
        asc_pkg::ADDR_CTRL_TWO: next_st.rdata = ctrl_to_word(st.ctrl);
        asc_pkg::ADDR_IRQ_STATUS: next_st.rdata = {13'h0000, st.status};
        asc_pkg::ADDR_IRQ_MASK: next_st.rdata = {13'h0000, st.mask};
        asc_pkg::ADDR_SEQ_STATE: next_st.rdata = {8'h00, st.phase, st.next_is_b, 1'b0, seq_count};
        default: next_st.rdata = 16'h0000;
      endcase
    end

    // Sample phase and mux alternation
    case (st.phase)
      asc_pkg::ASC_IDLE: begin
        if (sample_start) begin
          next_st.phase = asc_pkg::ASC_SAMPLE;
        end
      end
      asc_pkg::ASC_SAMPLE: begin
        next_st.phase = asc_pkg::ASC_CONVERT;
      end
      asc_pkg::ASC_CONVERT: begin
        // Mux turn holds for the whole sequence, flips when it completes
        if (seq_done) begin
          next_st.phase = asc_pkg::ASC_IDLE;
          if (!cal_restart) begin
            next_st.next_is_b = st.ctrl.alternate_mux_bit && !st.next_is_b;
          end
        end
      end
      default: next_st.phase = asc_pkg::ASC_IDLE;
    endcase

    // Analog steering
    next_st.ana.ref_select = st.ctrl.ref_config_field;
    next_st.ana.cal_mode = st.ctrl.offset_cal_bit;
    next_st.ana.inputs_to_ground = st.ctrl.offset_cal_bit;
    next_st.ana.switches_open = st.ctrl.offset_cal_bit;
    next_st.ana.scan_enable = st.ctrl.scan_first_mux_bit && !st.ctrl.offset_cal_bit;
    next_st.ana.use_mux_b = st.ctrl.alternate_mux_bit && st.next_is_b &&
      !st.ctrl.offset_cal_bit;
    // Calibration overrides pin config and channel selection
    if (st.ctrl.offset_cal_bit) begin
      next_st.sw_en = '0;
      next_st.chan = '0;
    end else begin
      next_st.sw_en = analog_pin_config_reg;
      next_st.chan = (st.ctrl.alternate_mux_bit && st.next_is_b) ? chan_sel_b : chan_sel_a;
    end

    // Sticky events; set wins over clear
    set_bits[asc_pkg::IRQ_SEQ_POS] = seq_event;
    set_bits[asc_pkg::IRQ_CAL_POS] = seq_done && st.ctrl.offset_cal_bit;
    set_bits[asc_pkg::IRQ_RSVD_POS] = seq_done &&
      (st.ctrl.sequences_per_irq_field == asc_pkg::SEQ_IRQ_RESERVED);
    next_st.status = next_st.status | set_bits;
    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign pin_switch_en = st.sw_en;
  assign conv_channel = st.chan;
  assign inputs_to_ground = st.ana.inputs_to_ground;
  assign ref_select = st.ana.ref_select;
  assign use_mux_b = st.ana.use_mux_b;
  assign scan_enable = st.ana.scan_enable;
  assign cal_mode = st.ana.cal_mode;
  assign irq = st.irq;

  // ********************************************
  // Checks
  // ********************************************
  AST_REF_FOLLOW: assert property (@(posedge ref_clk) disable iff (!resetn)
    1'b1 |=> ref_select == $past(st.ctrl.ref_config_field))
    else $error("reference select does not follow field");
  AST_CAL_MODE: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.ctrl.offset_cal_bit |=> cal_mode)
    else $error("calibration mode not entered");
  AST_CAL_GROUND: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.ctrl.offset_cal_bit |=> inputs_to_ground && pin_switch_en == '0)
    else $error("inputs not grounded in calibration");
  AST_CAL_NO_CHAN: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.ctrl.offset_cal_bit |=> conv_channel == '0 && !use_mux_b)
    else $error("channel leaks into calibration");
  AST_SCAN: assert property (@(posedge ref_clk) disable iff (!resetn)
    !st.ctrl.scan_first_mux_bit |=> !scan_enable)
    else $error("scan active while disabled");
  AST_SEQ_ZERO: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.ctrl.sequences_per_irq_field == 4'h0 && seq_done && !cal_restart |=> seq_event)
    else $error("no event after single sequence");
  AST_ALT_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
    !st.ctrl.alternate_mux_bit |=> !use_mux_b)
    else $error("mux B used without alternation");
  AST_UNIMPL_ZERO: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_en && addr == asc_pkg::ADDR_CTRL_TWO |=> (rdata & 16'h0bc0) == 16'h0000)
    else $error("unimplemented bits read nonzero");

  // ********************************************
  // Checks: modes and steering
  // ********************************************
  AST_REF_SUPPLY: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.ctrl.ref_config_field == asc_pkg::REF_SUPPLY_GROUND |=>
    ref_select == asc_pkg::REF_SUPPLY_GROUND)
    else $error("supply references not selected");
  AST_MEASURE_MODE: assert property (@(posedge ref_clk) disable iff (!resetn)
    !st.ctrl.offset_cal_bit |=> !cal_mode && !inputs_to_ground)
    else $error("measure mode shows calibration");
  AST_MEASURE_PINS: assert property (@(posedge ref_clk) disable iff (!resetn)
    !st.ctrl.offset_cal_bit |=> pin_switch_en == $past(analog_pin_config_reg))
    else $error("pin switches do not follow pin configuration");
  AST_CAL_STATUS: assert property (@(posedge ref_clk) disable iff (!resetn)
    seq_done && st.ctrl.offset_cal_bit |=> st.status[asc_pkg::IRQ_CAL_POS])
    else $error("calibration done flag not set");
  AST_CAL_SWITCHES: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.ctrl.offset_cal_bit |=> st.ana.switches_open)
    else $error("switches not opened in calibration");
  AST_SWITCHES_OPEN: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.ana.switches_open |-> pin_switch_en == '0 && inputs_to_ground)
    else $error("open switches still connect inputs");
  AST_CAL_SCAN_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.ctrl.offset_cal_bit |=> !scan_enable)
    else $error("scan active in calibration");
  AST_SCAN_ON: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.ctrl.scan_first_mux_bit && !st.ctrl.offset_cal_bit |=> scan_enable)
    else $error("scan not active while enabled");
  AST_ALT_FIRST: assert property (@(posedge ref_clk) disable iff (!resetn)
    cal_restart |-> ##2 !use_mux_b)
    else $error("first sample after rewrite not on mux A");
  AST_ALT_TOGGLE: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.phase == asc_pkg::ASC_CONVERT && seq_done && !cal_restart &&
    st.ctrl.alternate_mux_bit |=> st.next_is_b != $past(st.next_is_b))
    else $error("mux turn did not alternate");
  AST_ALT_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.phase != asc_pkg::ASC_CONVERT && !cal_restart |=> st.next_is_b == $past(st.next_is_b))
    else $error("mux turn changed outside a sequence end");
  AST_CHAN_A: assert property (@(posedge ref_clk) disable iff (!resetn)
    !st.ctrl.alternate_mux_bit && !st.ctrl.offset_cal_bit |=>
    conv_channel == $past(chan_sel_a))
    else $error("mux A channel not applied");
  AST_CHAN_B: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.ctrl.alternate_mux_bit && st.next_is_b && !st.ctrl.offset_cal_bit |=>
    use_mux_b && conv_channel == $past(chan_sel_b))
    else $error("mux B turn not applied");
  AST_SEQ_PHASE: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.phase == asc_pkg::ASC_SAMPLE |=> st.phase == asc_pkg::ASC_CONVERT)
    else $error("sample phase not followed by conversion");

  // ********************************************
  // Checks: events and bus
  // ********************************************
  AST_SEQ_STATUS: assert property (@(posedge ref_clk) disable iff (!resetn)
    seq_event |=> st.status[asc_pkg::IRQ_SEQ_POS])
    else $error("sequence event not latched");
  AST_SEQ_ONE_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.ctrl.sequences_per_irq_field == 4'h1 && seq_done && !cal_restart &&
    seq_count == 4'h0 |=> !seq_event && seq_count == 4'h1)
    else $error("event raised after first of two sequences");
  AST_SEQ_ONE_FIRE: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.ctrl.sequences_per_irq_field == 4'h1 && seq_done && !cal_restart &&
    seq_count == 4'h1 |=> seq_event && seq_count == 4'h0)
    else $error("no event after second sequence");
  AST_SEQ_RESTART: assert property (@(posedge ref_clk) disable iff (!resetn)
    cal_restart |=> seq_count == 4'h0 && !seq_event)
    else $error("sequence count not restarted");
  AST_RSVD_STATUS: assert property (@(posedge ref_clk) disable iff (!resetn)
    seq_done && st.ctrl.sequences_per_irq_field == asc_pkg::SEQ_IRQ_RESERVED |=>
    st.status[asc_pkg::IRQ_RSVD_POS])
    else $error("reserved code flag not set");
  AST_STATUS_STICKY: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.status[asc_pkg::IRQ_SEQ_POS] && !(wr_en && addr == asc_pkg::ADDR_IRQ_STATUS) |=>
    st.status[asc_pkg::IRQ_SEQ_POS])
    else $error("sequence flag lost without clear");
  AST_STATUS_CLEAR: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_en && addr == asc_pkg::ADDR_IRQ_STATUS && wdata[asc_pkg::IRQ_CAL_POS] &&
    !(seq_done && st.ctrl.offset_cal_bit) |=> !st.status[asc_pkg::IRQ_CAL_POS])
    else $error("calibration flag not cleared");
  AST_IRQ_MASKED: assert property (@(posedge ref_clk) disable iff (!resetn)
    st.mask == '0 && !wr_en |=> !irq)
    else $error("interrupt raised while fully masked");
  AST_RDATA_IDLE: assert property (@(posedge ref_clk) disable iff (!resetn)
    !rd_en |=> rdata == 16'h0000)
    else $error("read data not zero without a read");
  AST_CTRL_READBACK: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_en && addr == asc_pkg::ADDR_CTRL_TWO |=>
    rdata[asc_pkg::REF_CFG_MSB:asc_pkg::REF_CFG_LSB] == $past(st.ctrl.ref_config_field))
    else $error("reference field does not read back");

endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench for the converter sequence control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic ref_clk, resetn, wr_en, rd_en, sample_start, seq_done;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, rv;
  logic [11:0] pin_cfg, pin_switch_en;
  logic [3:0] chan_a, chan_b, conv_channel;
  logic inputs_to_ground, use_mux_b, scan_enable, cal_mode, irq;
  logic [2:0] ref_select;
  int err_count = 0;
  int checks = 0;

  asc_top i_asc_top (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sample_start(sample_start),
    .seq_done(seq_done), .analog_pin_config_reg(pin_cfg), .chan_sel_a(chan_a),
    .chan_sel_b(chan_b), .pin_switch_en(pin_switch_en), .conv_channel(conv_channel),
    .inputs_to_ground(inputs_to_ground), .ref_select(ref_select), .use_mux_b(use_mux_b),
    .scan_enable(scan_enable), .cal_mode(cal_mode), .irq(irq));

  // ********************************************
  // Bus and check helpers
  // ********************************************
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic pulse(input bit start);
    @(posedge ref_clk);
    if (start) sample_start <= 1'b1;
    else seq_done <= 1'b1;
    @(posedge ref_clk);
    sample_start <= 1'b0;
    seq_done <= 1'b0;
  endtask

  task automatic summarize();
    $display("Counts: %0d checks, %0d mismatches", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ********************************************
  // Scenarios
  // ********************************************
  task automatic t_regs();
    rd(asc_pkg::ADDR_CTRL_TWO, rv);
    chk("ctrl reset", asc_pkg::CTRL_RESET, rv);
    wr(asc_pkg::ADDR_CTRL_TWO, 16'hfffd);
    rd(asc_pkg::ADDR_CTRL_TWO, rv);
    chk("ctrl unimpl", 16'hf43d, rv & 16'hff7f);
    wr(4'h9, 16'hffff);
    rd(4'h9, rv);
    chk("unmapped", 16'h0000, rv);
    $display("test regs done");
  endtask

  task automatic t_cal();
    wr(asc_pkg::ADDR_CTRL_TWO, 16'hb400);
    idle(3);
    chk("cal_mode", 16'h0001, 16'(cal_mode));
    chk("ground", 16'h0001, 16'(inputs_to_ground));
    chk("switches", 16'h0000, 16'(pin_switch_en));
    chk("cal chan", 16'h0000, 16'(conv_channel));
    chk("cal scan", 16'h0000, 16'(scan_enable));
    chk("ref", 16'h0005, 16'(ref_select));
    pulse(1'b0);
    idle(2);
    rd(asc_pkg::ADDR_IRQ_STATUS, rv);
    chk("cal result", 16'h0003, rv);
    wr(asc_pkg::ADDR_CTRL_TWO, 16'h0400);
    idle(3);
    chk("scan on", 16'h0001, 16'(scan_enable));
    chk("norm sw", 16'(pin_cfg), 16'(pin_switch_en));
    chk("ref sup", 16'(asc_pkg::REF_SUPPLY_GROUND), 16'(ref_select));
    chk("norm gnd", 16'h0000, 16'(inputs_to_ground));
    wr(asc_pkg::ADDR_CTRL_TWO, 16'h0000);
    idle(3);
    chk("scan off", 16'h0000, 16'(scan_enable));
    $display("test cal done");
  endtask

  task automatic t_irq(input logic [3:0] code);
    int i;
    wr(asc_pkg::ADDR_CTRL_TWO, {10'h0, code, 2'h0});
    wr(asc_pkg::ADDR_IRQ_STATUS, 16'h0007);
    wr(asc_pkg::ADDR_IRQ_MASK, 16'h0001);
    rd(asc_pkg::ADDR_IRQ_MASK, rv);
    chk("mask", 16'h0001, rv);
    for (i = 0; i < int'(code); i++) begin
      pulse(1'b0);
      idle(5);
      chk("irq early", 16'h0000, 16'(irq));
      rd(asc_pkg::ADDR_SEQ_STATE, rv);
      chk("seq count", 16'(i + 1), rv);
    end
    pulse(1'b0);
    i = 0;
    while (irq !== 1'b1 && i < 10) begin
      idle(1);
      i++;
    end
    chk("irq due", 16'h0001, 16'(irq));
    if (irq !== 1'b1) summarize();
    rd(asc_pkg::ADDR_IRQ_STATUS, rv);
    chk("status", 16'h0001, rv);
    wr(asc_pkg::ADDR_IRQ_STATUS, 16'h0001);
    idle(3);
    chk("irq clr", 16'h0000, 16'(irq));
    $display("test irq code %0d done", code);
  endtask

  task automatic t_rsvd_code();
    wr(asc_pkg::ADDR_CTRL_TWO, {10'h0, asc_pkg::SEQ_IRQ_RESERVED, 2'h0});
    wr(asc_pkg::ADDR_IRQ_MASK, 16'h0000);
    pulse(1'b0);
    idle(4);
    rd(asc_pkg::ADDR_IRQ_STATUS, rv);
    chk("rsvd code", 16'h0004, rv);
    chk("masked irq", 16'h0000, 16'(irq));
    wr(asc_pkg::ADDR_IRQ_STATUS, 16'h0007);
    $display("test reserved code done");
  endtask

  task automatic t_alt(input logic alt);
    int k;
    logic b;
    wr(asc_pkg::ADDR_CTRL_TWO, {15'h0, alt});
    for (k = 0; k < 4; k++) begin
      b = alt & k[0];
      pulse(1'b1);
      idle(3);
      chk("mux b", 16'(b), 16'(use_mux_b));
      chk("chan", 16'(b ? chan_b : chan_a), 16'(conv_channel));
      pulse(1'b0);
      idle(3);
    end
    $display("test alt %0d done", alt);
  endtask

  // ********************************************
  // Clock, reset and main sequence
  // ********************************************
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    #2000000;
    err_count++;
    summarize();
  end

  initial begin
    resetn = 1'b0;
    {wr_en, rd_en, sample_start, seq_done} = 4'h0;
    addr = 4'h0;
    wdata = 16'h0000;
    pin_cfg = 12'ha5a;
    chan_a = 4'h3;
    chan_b = 4'hc;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    idle(1);
    chk("reset out", 16'h0000, 16'({cal_mode, scan_enable, use_mux_b, irq, ref_select}));
    t_regs();
    t_cal();
    t_irq(4'h0);
    t_irq(4'h1);
    t_rsvd_code();
    t_alt(1'b1);
    t_alt(1'b0);
    summarize();
  end
endmodule
`default_nettype wire
